// *** rtl/eprg_ctrl.sv ***
// Programmer controller that writes, verifies and reads the signature of the memory
// Summary of operation
// - Write mode needs programming supply raised and chip select low.
// - Byte to write is driven on all eight byte lines during pulse.
// - Each write pulse holds chip select low 95 to 105 us.
// - Programming supply raised at least 2 us before chip select falls.
// - Release data drive, wait 2 us, then output gate low for verify.
// - Repeat 100 us pulses, verifying after each, until read-back matches; code gives up with fail after 25 pulses or when a bit needs 0 to 1.
// - No extra pulse after a passing verify.
// - Shared inputs across parts; each part has its own chip select. Code drives one part through a single cs_n.
// - Verify read with output gate low, chip select high, supplies raised.
// - Signature mode: high voltage on id_hv_line, supplies at 5V.
// - In signature mode all address lines low except sig_sel_line.
`timescale 1ns/1ps
`include "eprg_params.svh"
module eprg_ctrl (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Request side
    input wire logic req_valid_i,
    output logic req_ready_o,
    input eprg_pkg::eprg_req_t req_i,
    output logic rsp_valid_o,
    output eprg_pkg::eprg_rsp_t rsp_o,
    // Memory pins
    output eprg_pkg::eprg_pins_t pins_o,
    input wire logic [7:0] byte_lines_i,
    output logic [7:0] byte_lines_o,
    output logic byte_lines_oe_n_o
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_GATE, ST_SAMPLE, ST_DONE
    } eprg_st_t;

    eprg_st_t st_r, st_nxt;
    eprg_pkg::eprg_req_t req_r, req_nxt;
    eprg_pkg::eprg_rsp_t rsp_r, rsp_nxt;
    eprg_pkg::eprg_pins_t pins_r, pins_nxt;
    logic [`EPRG_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [7:0] dout_r, dout_nxt;
    logic drive_r, drive_nxt;
    logic rsp_v_r, rsp_v_nxt;

    function automatic logic [`EPRG_CNT_W-1:0] cyc(input int n);
        cyc = `EPRG_CNT_W'(n - 1);
    endfunction : cyc

    // Blank target is already met by the erased cell: no drive, no pulse
    function automatic logic needs_pulse(input eprg_pkg::eprg_req_t r);
        needs_pulse = (r.op == eprg_pkg::EPRG_OP_PROG) && (r.data != `EPRG_BLANK_BYTE);
    endfunction : needs_pulse

    // Idle pins: supplies at 5V, controls high, nothing driven
    function automatic eprg_pkg::eprg_pins_t idle_pins();
        idle_pins = '{vpp_hi: 1'b0, vcc_hi: 1'b0, id_hv: 1'b0, cs_n: 1'b1,
                      oe_n: 1'b1, addr: 19'h0};
    endfunction : idle_pins

    assign req_ready_o = (st_r == ST_IDLE);
    assign rsp_valid_o = rsp_v_r;
    assign rsp_o = rsp_r;
    assign pins_o = pins_r;
    assign byte_lines_o = dout_r;
    assign byte_lines_oe_n_o = ~drive_r;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        req_nxt = req_r;
        rsp_nxt = rsp_r;
        pins_nxt = pins_r;
        cnt_nxt = cnt_r;
        dout_nxt = dout_r;
        drive_nxt = drive_r;
        rsp_v_nxt = 1'b0;
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        case (st_r)
            ST_IDLE: begin
                pins_nxt = idle_pins();
                drive_nxt = 1'b0;
                if (req_valid_i) begin
                    req_nxt = req_i;
                    rsp_nxt = '0;
                    cnt_nxt = cyc(`EPRG_CYC_SETUP);
                    st_nxt = ST_SETUP;
                    if (req_i.op == eprg_pkg::EPRG_OP_SIG) begin
                        pins_nxt.id_hv = 1'b1;
                        pins_nxt.addr = {18'h0, req_i.addr[0]};
                    end else begin
                        pins_nxt.vpp_hi = 1'b1;
                        pins_nxt.vcc_hi = 1'b1;
                        pins_nxt.addr = req_i.addr;
                        if (needs_pulse(req_i)) begin
                            dout_nxt = req_i.data;
                            drive_nxt = 1'b1;
                        end
                    end
                end
            end
            ST_SETUP: begin
                if (cnt_r == '0) begin
                    if (needs_pulse(req_r)) begin
                        pins_nxt.cs_n = 1'b0;
                        cnt_nxt = cyc(`EPRG_CYC_PW);
                        rsp_nxt.pulses = rsp_r.pulses + 1'b1;
                        st_nxt = ST_PULSE;
                    end else begin
                        // Blank target byte is already met by the erased cell
                        pins_nxt.oe_n = 1'b0;
                        cnt_nxt = cyc(`EPRG_CYC_GLQV);
                        st_nxt = ST_GATE;
                    end
                end
            end
            ST_PULSE: begin
                if (cnt_r == '0) begin
                    pins_nxt.cs_n = 1'b1;
                    cnt_nxt = cyc(`EPRG_CYC_SETUP);
                    st_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Data held after chip select rises, then released before gating
                if (cnt_r == '0) begin
                    if (drive_r) begin
                        drive_nxt = 1'b0;
                        cnt_nxt = cyc(`EPRG_CYC_SETUP);
                    end else begin
                        pins_nxt.oe_n = 1'b0;
                        cnt_nxt = cyc(`EPRG_CYC_GLQV);
                        st_nxt = ST_GATE;
                    end
                end
            end
            ST_GATE: begin
                if (cnt_r == '0) begin
                    st_nxt = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                rsp_nxt.data = byte_lines_i;
                pins_nxt.oe_n = 1'b1;
                cnt_nxt = cyc(`EPRG_CYC_GHQZ);
                st_nxt = ST_DONE;
                if (req_r.op == eprg_pkg::EPRG_OP_PROG
                    && byte_lines_i != req_r.data) begin
                    if ((~byte_lines_i & req_r.data) != 8'h0
                        || rsp_r.pulses == `EPRG_TRY_W'(`EPRG_MAX_PULSES)) begin
                        rsp_nxt.fail = 1'b1;
                    end else begin
                        dout_nxt = req_r.data;
                        cnt_nxt = cyc(`EPRG_CYC_GHQZ + `EPRG_CYC_SETUP);
                        st_nxt = ST_SETUP;
                    end
                end
            end
            ST_DONE: begin
                // Match ends the byte with no further pulse
                if (cnt_r == '0) begin
                    pins_nxt = idle_pins();
                    rsp_v_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // Retry redrives data only once the output gate is back high
        // A blank target must stay released, or the gate would fall onto a driven bus
        if (st_r == ST_SETUP && needs_pulse(req_r) && pins_r.oe_n) begin
            drive_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= ST_IDLE;
            req_r <= '0;
            rsp_r <= '0;
            pins_r <= '{vpp_hi: 1'b0, vcc_hi: 1'b0, id_hv: 1'b0, cs_n: 1'b1,
                        oe_n: 1'b1, addr: 19'h0};
            cnt_r <= '0;
            dout_r <= 8'h00;
            drive_r <= 1'b0;
            rsp_v_r <= 1'b0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
            req_r <= req_nxt;
            rsp_r <= rsp_nxt;
            pins_r <= pins_nxt;
            cnt_r <= cnt_nxt;
            dout_r <= dout_nxt;
            drive_r <= drive_nxt;
            rsp_v_r <= rsp_v_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [`EPRG_CNT_W-1:0] pw_r;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pw_r <= '0;
        end else if (clk_en_i) begin
            pw_r <= pins_r.cs_n ? '0 : pw_r + 1'b1;
        end
    end

    AST_NO_CONTENTION: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(drive_r && !pins_r.oe_n)) else $error("byte lines driven while gate low");
    AST_PW_MAX: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pw_r <= `EPRG_CNT_W'(`EPRG_CYC_PW_MAX)) else $error("pulse too long");
    AST_PW_MIN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && $rose(pins_r.cs_n) |-> $past(pw_r) >= `EPRG_CNT_W'(`EPRG_CYC_PW_MIN - 1))
        else $error("pulse too short");
    AST_VPP_BEFORE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !pins_r.cs_n |-> pins_r.vpp_hi && pins_r.vcc_hi) else $error("pulse without supply");
    AST_DATA_IN_PULSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !pins_r.cs_n |-> drive_r && dout_r == req_r.data) else $error("no data in pulse");
    AST_VERIFY_CS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !pins_r.oe_n |-> pins_r.cs_n) else $error("gate and select both low");
    AST_SIG_ADDR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pins_r.id_hv |-> pins_r.addr[18:1] == 18'h0 && !pins_r.vpp_hi)
        else $error("signature address lines not low");
    AST_TRY_BOUND: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rsp_r.pulses <= `EPRG_TRY_W'(`EPRG_MAX_PULSES)) else $error("too many pulses");
    AST_NO_EXTRA: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_r == ST_DONE |-> pins_r.cs_n) else $error("pulse after verify");

    COV_PROG: cover property (@(posedge ref_clk_i) rsp_v_r && req_r.op == eprg_pkg::EPRG_OP_PROG
        && !rsp_r.fail);
    COV_RETRY: cover property (@(posedge ref_clk_i) rsp_v_r && rsp_r.pulses > 8'h1);
    COV_FAIL: cover property (@(posedge ref_clk_i) rsp_v_r && rsp_r.fail);
    COV_SIG: cover property (@(posedge ref_clk_i) rsp_v_r && req_r.op == eprg_pkg::EPRG_OP_SIG);
endmodule : eprg_ctrl

// *** inc/eprg_params.svh ***
// Timing constants, pulse limit, blank byte and counter widths for the programmer controller
`ifndef EPRG_PARAMS_SVH
`define EPRG_PARAMS_SVH
`define EPRG_CLK_MHZ 100
`define EPRG_T_SETUP_US 2
`define EPRG_T_PW_MIN_US 95
`define EPRG_T_PW_MAX_US 105
`define EPRG_T_PW_NOM_US 100
`define EPRG_T_GLQV_NS 100
`define EPRG_T_GHQZ_NS 130
`define EPRG_CYC_SETUP (`EPRG_T_SETUP_US * `EPRG_CLK_MHZ)
`define EPRG_CYC_PW (`EPRG_T_PW_NOM_US * `EPRG_CLK_MHZ)
`define EPRG_CYC_PW_MIN (`EPRG_T_PW_MIN_US * `EPRG_CLK_MHZ)
`define EPRG_CYC_PW_MAX (`EPRG_T_PW_MAX_US * `EPRG_CLK_MHZ)
`define EPRG_CYC_GLQV ((`EPRG_T_GLQV_NS * `EPRG_CLK_MHZ + 999) / 1000)
`define EPRG_CYC_GHQZ ((`EPRG_T_GHQZ_NS * `EPRG_CLK_MHZ + 999) / 1000)
`define EPRG_MAX_PULSES 25
`define EPRG_BLANK_BYTE 8'hff
`define EPRG_CNT_W 16
`define EPRG_TRY_W 8
`endif

// *** inc/eprg_pkg.sv ***
// Types shared by the programmer controller
package eprg_pkg;
    typedef enum logic [1:0] {
        EPRG_OP_PROG,
        EPRG_OP_VERIFY,
        EPRG_OP_SIG
    } eprg_op_t;

    typedef struct packed {
        eprg_op_t op;
        logic [18:0] addr;
        logic [7:0] data;
    } eprg_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic fail;
        logic [7:0] pulses;
    } eprg_rsp_t;

    typedef struct packed {
        logic vpp_hi;
        logic vcc_hi;
        logic id_hv;
        logic cs_n;
        logic oe_n;
        logic [18:0] addr;
    } eprg_pins_t;
endpackage : eprg_pkg

// *** sim/eprg_mem_model.sv ***
// Behavioural model of the byte-wide memory as seen at its pins
`timescale 1ns/1ps
module eprg_mem_model #(
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
    parameter logic [7:0] PART = 8'hc3 // Arbitrary value
) (
    // Memory pins
    input eprg_pkg::eprg_pins_t pins_i,
    input wire logic [7:0] ctrl_data_i,
    input wire logic ctrl_oe_n_i,
    // Pulses a byte needs before it reads back
    input wire logic [7:0] need_i,
    // Resolved byte lines and rule breaches seen
    output logic [7:0] bus_o,
    output int err_o
);
    // ************************************
    // Array, write pulses and pin timing
    // ************************************
    logic [7:0] mem [logic [18:0]];
    int hits [logic [18:0]];
    logic [7:0] cap = 8'h00;
    logic [7:0] last = 8'h00;
    logic pulsed = 1'b0;
    realtime t_vpp = 0.0;
    realtime t_cs = 0.0;
    realtime t_rel = 0.0;
    logic rd_mode;
    logic sig_mode;
    function automatic logic [7:0] rd(input logic [18:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction : rd
    assign rd_mode = !pins_i.oe_n && pins_i.cs_n && pins_i.vpp_hi && pins_i.vcc_hi;
    assign sig_mode = !pins_i.oe_n && pins_i.id_hv && !pins_i.vpp_hi && !pins_i.vcc_hi;
    initial err_o = 0;
    always @(posedge pins_i.vpp_hi) t_vpp = $realtime;
    always @(posedge ctrl_oe_n_i) t_rel = $realtime;
    always @(negedge pins_i.cs_n) begin
        t_cs = $realtime;
        cap = ctrl_data_i;
        if (pins_i.vpp_hi === 1'b1) begin
            if ($realtime - t_vpp < 2000.0) err_o++;
            if (ctrl_oe_n_i !== 1'b0) err_o++;
            if (rd(pins_i.addr) == cap) err_o++;
        end
    end
    always @(posedge pins_i.cs_n) begin
        if (pins_i.vpp_hi === 1'b1 && pins_i.vcc_hi === 1'b1) begin
            if ($realtime - t_cs < 95000.0 || $realtime - t_cs > 105000.0) err_o++;
            pulsed = 1'b1;
            hits[pins_i.addr] = hits.exists(pins_i.addr) ? hits[pins_i.addr] + 1 : 1;
            // Weak cells need several pulses, so a slow byte exercises the retry loop
            if (hits[pins_i.addr] >= need_i) mem[pins_i.addr] = rd(pins_i.addr) & cap;
        end
    end
    always @(negedge pins_i.oe_n) begin
        if (ctrl_oe_n_i !== 1'b1) err_o++;
        if (pulsed && $realtime - t_rel < 2000.0) err_o++;
        if (pins_i.id_hv === 1'b1 && pins_i.addr[18:1] !== 18'h00000) err_o++;
        pulsed = 1'b0;
    end
    always @(negedge ctrl_oe_n_i) if (pins_i.oe_n === 1'b0) err_o++;
    // Released lines show the inverse of their last value, never a kind stale copy
    always @* begin
        bus_o = ~last;
        if (rd_mode) bus_o = rd(pins_i.addr);
        else if (sig_mode) bus_o = pins_i.addr[0] ? PART : MAKER;
        else if (ctrl_oe_n_i === 1'b0) bus_o = ctrl_data_i;
    end
    always @(bus_o) if (rd_mode || sig_mode || ctrl_oe_n_i === 1'b0) last = bus_o;
endmodule : eprg_mem_model

// *** sim/eprom_program_verify_signature_bench.sv ***
// Self-checking bench for the programmer controller against the memory model
`timescale 1ns/1ps
module eprom_program_verify_signature_bench;
    // ************************************
    // Harness
    // ************************************
    localparam logic [7:0] MAKER_CODE = 8'h3c; // Arbitrary value
    localparam logic [7:0] PART_CODE = 8'hc3; // Arbitrary value
    logic ref_clk_i, rst_i, clk_en_i, req_valid_i, req_ready_o, rsp_valid_o;
    logic byte_lines_oe_n_o;
    logic [7:0] byte_lines_i, byte_lines_o;
    logic [7:0] need = 8'h01;
    eprg_pkg::eprg_req_t req_i;
    eprg_pkg::eprg_rsp_t rsp_o;
    eprg_pkg::eprg_pins_t pins_o;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int model_err;
    eprg_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .pins_o(pins_o), .byte_lines_i(byte_lines_i),
        .byte_lines_o(byte_lines_o), .byte_lines_oe_n_o(byte_lines_oe_n_o));
    eprg_mem_model #(.MAKER(MAKER_CODE), .PART(PART_CODE)) MEM (.pins_i(pins_o),
        .ctrl_data_i(byte_lines_o), .ctrl_oe_n_i(byte_lines_oe_n_o), .need_i(need),
        .bus_o(byte_lines_i), .err_o(model_err));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic complete_run;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // Four pulses of about 10600 cycles plus reads fit well inside this ceiling
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles >= 80000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : expect8
    task automatic run_op(input eprg_pkg::eprg_op_t op, input logic [18:0] a,
                          input logic [7:0] d);
        int n;
        logic ok;
        @(negedge ref_clk_i);
        req_i = '{op: op, addr: a, data: d};
        req_valid_i = 1'b1;
        n = 0;
        do begin
            ok = req_ready_o;
            @(negedge ref_clk_i);
            n++;
        end while (ok !== 1'b1 && n < 100);
        req_valid_i = 1'b0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 30000) begin
            @(negedge ref_clk_i);
            n++;
        end
        expect8({7'h00, rsp_valid_o}, 8'h01);
    endtask : run_op
    task automatic prog_and_read(input logic [18:0] a, input logic [7:0] d, input logic [7:0] p);
        run_op(eprg_pkg::EPRG_OP_PROG, a, d);
        expect8(rsp_o.pulses, p);
        expect8({7'h00, rsp_o.fail}, 8'h00);
        run_op(eprg_pkg::EPRG_OP_VERIFY, a, 8'h00);
        expect8(rsp_o.data, d);
    endtask : prog_and_read
    // ************************************
    // Scenarios
    // ************************************
    task automatic test_blank;
        run_op(eprg_pkg::EPRG_OP_VERIFY, 19'h00010, 8'h00);
        expect8(rsp_o.data, 8'hff);
    endtask : test_blank
    task automatic test_freeze;
        @(negedge ref_clk_i);
        clk_en_i = 1'b0;
        req_i = '{op: eprg_pkg::EPRG_OP_VERIFY, addr: 19'h00010, data: 8'h00};
        req_valid_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        expect8({7'h00, pins_o.vpp_hi}, 8'h00);
        req_valid_i = 1'b0;
        clk_en_i = 1'b1;
    endtask : test_freeze
    task automatic test_one_pulse;
        need = 8'h01;
        prog_and_read(19'h00020, 8'h5a, 8'h01);
    endtask : test_one_pulse
    task automatic test_zero_to_one;
        run_op(eprg_pkg::EPRG_OP_PROG, 19'h00020, 8'h7e);
        expect8({7'h00, rsp_o.fail}, 8'h01);
        run_op(eprg_pkg::EPRG_OP_VERIFY, 19'h00020, 8'h00);
        expect8(rsp_o.data, 8'h5a);
    endtask : test_zero_to_one
    task automatic test_retry;
        need = 8'h02;
        prog_and_read(19'h7ffff, 8'h00, 8'h02);
    endtask : test_retry
    task automatic test_blank_target;
        prog_and_read(19'h00030, 8'hff, 8'h00);
    endtask : test_blank_target
    task automatic test_signature;
        run_op(eprg_pkg::EPRG_OP_SIG, 19'h00000, 8'h00);
        expect8(rsp_o.data, MAKER_CODE);
        run_op(eprg_pkg::EPRG_OP_SIG, 19'h40201, 8'h00);
        expect8(rsp_o.data, PART_CODE);
    endtask : test_signature
    initial begin
        rst_i = 1'b1;
        clk_en_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        repeat (4) @(negedge ref_clk_i);
        rst_i = 1'b0;
        test_blank();
        test_freeze();
        test_one_pulse();
        test_zero_to_one();
        test_retry();
        test_blank_target();
        test_signature();
        expect8((model_err == 0) ? 8'h00 : 8'h01, 8'h00);
        complete_run();
    end
endmodule : eprom_program_verify_signature_bench
